// *** inc/dcs_cfg.svh ***
// Function
// - same-row write-to-read delay fixed one clock
// - precharge waits write recovery: 2 or 3
// - cross-row write-to-read spacing 4/3/2 clocks
// - write data starts one clock after write
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH

// register map
`define DCS_TIMING_OFFSET 8'h60
`define DCS_TIMING_RESET  32'h18004425

// field positions of dram_command_timing
`define DCS_WTR_BIT       31
`define DCS_TWR_BIT       30
`define DCS_WRRD_HI       29
`define DCS_WRRD_LO       28

// spacing counts in clocks
`define DCS_WTR_CLKS      3'h1
`define DCS_TWR_SHORT     3'h2
`define DCS_TWR_LONG      3'h3
`define DCS_WRRD_ENC0     3'h4
`define DCS_WRRD_ENC1     3'h3
`define DCS_WRRD_ENC2     3'h2
`define DCS_DATA_LAG      1

`endif

// *** inc/dcs_pkg.sv ***
package dcs_pkg;

    localparam int DCS_BANK_W = 2;
    localparam int DCS_ROW_W  = 13;

    // command kinds seen by the spacing gate
    typedef enum logic [2:0] {
        dcs_nop = 3'h0,
        dcs_act = 3'h1,
        dcs_rd  = 3'h2,
        dcs_wr  = 3'h3,
        dcs_pre = 3'h4
    } dcs_kind_t;

    typedef struct packed {
        dcs_kind_t               kind;
        logic [DCS_BANK_W-1:0]   bank;
        logic [DCS_ROW_W-1:0]    row;
    } dcs_cmd_t;

endpackage : dcs_pkg

// *** rtl/dcs_gap_timer.sv ***
`timescale 1ns/1ps
// clocks elapsed since the last start, saturating
module dcs_gap_timer #(
    parameter int CNT_W = 3
) (
    input  wire logic             clock_in,
    input  wire logic             rstn_in,
    input  wire logic             start_in,
    output logic [CNT_W-1:0]      count_out
);
    // refuse a counter too narrow to saturate usefully
    if (CNT_W < 2) begin : g_bad_cnt
        $error("dcs_gap_timer: CNT_W too small");
    end

    logic [CNT_W-1:0] count_reg;
    wire              at_max = &count_reg;

    // reset reads as long ago, so nothing is held off
    always_ff @(posedge clock_in) begin
        if (!rstn_in)
            count_reg <= '1;
        else if (start_in)
            count_reg <= '0;
        else if (!at_max)
            count_reg <= count_reg + 1'b1;
    end

    assign count_out = count_reg;
endmodule : dcs_gap_timer

// *** rtl/dcs_timing_top.sv ***
`timescale 1ns/1ps
`include "dcs_cfg.svh"
// command spacing gate of the ddr controller
module dcs_timing_top
    import dcs_pkg::*;
#(
    parameter int NUM_BANKS = 4,
    parameter int CNT_W     = 3
) (
    input  wire logic          clock_in,
    input  wire logic          rstn_in,
    // scheduler request, held until accepted
    input  wire logic          cmd_valid_in,
    input  wire dcs_cmd_t      cmd_in,
    output logic               cmd_accept_out,
    // command toward the memory
    output logic               issue_valid_out,
    output dcs_cmd_t           issue_cmd_out,
    output logic               write_data_start_out,
    // configuration register port
    input  wire logic          reg_wr_in,
    input  wire logic          reg_rd_in,
    input  wire logic [7:0]    reg_addr_in,
    input  wire logic [3:0]    reg_be_in,
    input  wire logic [31:0]   reg_wdata_in,
    output logic [31:0]        reg_rdata_out
);
    // refuse sizes the logic cannot serve
    if (NUM_BANKS < 1 || NUM_BANKS > (1 << DCS_BANK_W)) begin : g_bad_banks
        $error("dcs_timing_top: NUM_BANKS out of range");
    end
    if (CNT_W < 3) begin : g_bad_cnt
        $error("dcs_timing_top: CNT_W must hold the longest spacing");
    end

    logic [31:0]           timing_reg;
    logic [31:0]           timing_next;
    logic [31:0]           rdata_reg;
    logic                  accept_reg;
    logic                  issue_valid_reg;
    dcs_cmd_t              issue_cmd_reg;
    logic                  data_start_reg;
    logic                  last_wr_valid_reg;
    logic [DCS_BANK_W-1:0] last_bank_reg;
    logic [DCS_ROW_W-1:0]  last_row_reg;
    logic [CNT_W-1:0]      wr_count;
    logic [CNT_W-1:0]      bank_count [NUM_BANKS];

    // register decode
    wire reg_hit   = (reg_addr_in == `DCS_TIMING_OFFSET);
    wire reg_write = reg_wr_in & reg_hit;
    wire reg_read  = reg_rd_in;

    // byte-lane merge of a register write
    always_comb begin
        timing_next = timing_reg;
        for (int i = 0; i < 4; i++) begin
            if (reg_be_in[i])
                timing_next[i*8 +: 8] = reg_wdata_in[i*8 +: 8];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in)
            timing_reg <= `DCS_TIMING_RESET;
        else if (reg_write)
            timing_reg <= timing_next;
    end

    // read data, unmapped offsets read zero
    always_ff @(posedge clock_in) begin
        if (!rstn_in)
            rdata_reg <= 32'h0000_0000;
        else if (reg_read)
            rdata_reg <= reg_hit ? timing_reg : 32'h0000_0000;
    end

    // same-row delay, reserved code treated as one clock
    wire [2:0] wtr_need = `DCS_WTR_CLKS;

    wire [2:0] twr_need = timing_reg[`DCS_TWR_BIT] ? `DCS_TWR_LONG : `DCS_TWR_SHORT;

    // cross-row spacing, reserved code held to the widest
    wire [1:0] wrrd_code = timing_reg[`DCS_WRRD_HI:`DCS_WRRD_LO];
    wire [2:0] wrrd_need = (wrrd_code == 2'h1) ? `DCS_WRRD_ENC1 :
                           (wrrd_code == 2'h2) ? `DCS_WRRD_ENC2 : `DCS_WRRD_ENC0;

    // request classification
    wire is_rd    = (cmd_in.kind == dcs_rd);
    wire is_wr    = (cmd_in.kind == dcs_wr);
    wire is_pre   = (cmd_in.kind == dcs_pre);
    wire is_nop   = (cmd_in.kind == dcs_nop);
    wire same_row = last_wr_valid_reg & (cmd_in.bank == last_bank_reg) & (cmd_in.row == last_row_reg);

    // counts are zero in the issue cycle, a request goes out one clock later
    wire [2:0]       rd_need    = same_row ? wtr_need : wrrd_need;
    wire [CNT_W-1:0] rd_thresh  = CNT_W'(rd_need - 3'h1);
    wire [CNT_W-1:0] pre_thresh = CNT_W'(twr_need - 3'h1);
    wire [CNT_W-1:0] pre_count  = (int'(cmd_in.bank) < NUM_BANKS) ? bank_count[cmd_in.bank] : '1;

    wire rd_ok  = (wr_count >= rd_thresh);
    wire pre_ok = (pre_count >= pre_thresh);

    wire allowed   = is_rd ? rd_ok : (is_pre ? pre_ok : 1'b1);
    wire accept    = cmd_valid_in & ~is_nop & allowed & ~accept_reg;
    wire wr_accept = accept & is_wr;

    // time since the last write on any bank
    dcs_gap_timer #(.CNT_W(CNT_W)) u_wr_timer (
        .clock_in  (clock_in),
        .rstn_in   (rstn_in),
        .start_in  (wr_accept),
        .count_out (wr_count)
    );

    // time since the last write to each bank
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        wire bank_start = wr_accept & (int'(cmd_in.bank) == b);
        dcs_gap_timer #(.CNT_W(CNT_W)) u_bank_timer (
            .clock_in  (clock_in),
            .rstn_in   (rstn_in),
            .start_in  (bank_start),
            .count_out (bank_count[b])
        );
    end

    // last write target, for the same-row test
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            last_wr_valid_reg <= 1'b0;
            last_bank_reg     <= '0;
            last_row_reg      <= '0;
        end else if (wr_accept) begin
            last_wr_valid_reg <= 1'b1;
            last_bank_reg     <= cmd_in.bank;
            last_row_reg      <= cmd_in.row;
        end
    end

    // issue stage, one clock after acceptance
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            accept_reg      <= 1'b0;
            issue_valid_reg <= 1'b0;
            issue_cmd_reg   <= '0;
        end else begin
            accept_reg      <= accept;
            issue_valid_reg <= accept;
            issue_cmd_reg   <= accept ? cmd_in : '0;
        end
    end

    // data one clock after the write
    always_ff @(posedge clock_in) begin
        if (!rstn_in)
            data_start_reg <= 1'b0;
        else
            data_start_reg <= issue_valid_reg & (issue_cmd_reg.kind == dcs_wr);
    end

    assign cmd_accept_out       = accept_reg;
    assign issue_valid_out      = issue_valid_reg;
    assign issue_cmd_out        = issue_cmd_reg;
    assign write_data_start_out = data_start_reg;
    assign reg_rdata_out        = rdata_reg;
endmodule : dcs_timing_top

// *** dv/dcs_mem_model.sv ***
`timescale 1ns/1ps
// memory side: counts precharges and data starts that break its timing needs
module dcs_mem_model
    import dcs_pkg::*;
(
    input  wire logic     clock_in,
    input  wire logic     rstn_in,
    input  wire logic     issue_valid_out,
    input  wire dcs_cmd_t issue_cmd_out,
    input  wire logic     write_data_start_out,
    output logic [7:0]    viol_out
);
    logic [2:0] since_reg;
    logic [1:0] bank_reg;
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            since_reg <= 3'h7;
            bank_reg  <= 2'h0;
            viol_out  <= 8'h00;
        end else begin
            since_reg <= (issue_valid_out && issue_cmd_out.kind == dcs_wr) ? 3'h1 :
                         (since_reg == 3'h7) ? since_reg : since_reg + 3'h1;
            if (issue_valid_out && issue_cmd_out.kind == dcs_wr) bank_reg <= issue_cmd_out.bank;
            if ((write_data_start_out !== (since_reg == 3'h1)) ||
                (issue_valid_out && issue_cmd_out.kind == dcs_pre && issue_cmd_out.bank == bank_reg &&
                 since_reg < 3'h2))
                viol_out <= viol_out + 8'h01;
        end
    end
endmodule : dcs_mem_model

// *** dv/dcs_timing_props.sv ***
`timescale 1ns/1ps
// spacing checks seen from the top ports
module dcs_timing_chk
    import dcs_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    input  wire logic        reg_wr_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [3:0]  reg_be_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        issue_valid_out,
    input  wire dcs_cmd_t    issue_cmd_out,
    input  wire logic        write_data_start_out
);
    logic [7:0]  top_reg;
    logic [14:0] wa_reg;
    wire wr_iss = issue_valid_out && issue_cmd_out.kind == dcs_wr;
    wire rd_x   = issue_valid_out && issue_cmd_out.kind == dcs_rd && {issue_cmd_out.bank, issue_cmd_out.row} != wa_reg;
    wire pre_s  = issue_valid_out && issue_cmd_out.kind == dcs_pre && issue_cmd_out.bank == wa_reg[14:13];
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    // shadow of timing byte, last write address
    always_ff @(posedge clock_in) begin
        if (!rstn_in) top_reg <= 8'h18;
        else if (reg_wr_in && reg_addr_in == 8'h60 && reg_be_in[3]) top_reg <= reg_wdata_in[31:24];
        if (wr_iss) wa_reg <= {issue_cmd_out.bank, issue_cmd_out.row};
    end
    property p_data_lag; wr_iss |=> write_data_start_out; endproperty
    a_data_lag: assert property (p_data_lag) else $error("data start missing");
    property p_data_cause; write_data_start_out |-> $past(wr_iss); endproperty
    a_data_cause: assert property (p_data_cause) else $error("stray data start");
    property p_pre_gap; wr_iss && top_reg[6] |-> ##2 !pre_s; endproperty
    a_pre_gap: assert property (p_pre_gap) else $error("precharge too early");
    property p_rd_gap3; wr_iss && top_reg[5:4] != 2'h2 |-> ##2 !rd_x; endproperty
    a_rd_gap3: assert property (p_rd_gap3) else $error("read too early");
    property p_rd_gap4; wr_iss && top_reg[5:4] inside {2'h0, 2'h3} |-> ##3 !rd_x; endproperty
    a_rd_gap4: assert property (p_rd_gap4) else $error("read too early");
    c_rd2: cover property (wr_iss ##2 rd_x);
    c_rd4: cover property (wr_iss ##4 rd_x);
    c_pre3: cover property (wr_iss ##3 pre_s);
endmodule : dcs_timing_chk
bind dcs_timing_top dcs_timing_chk u_dcs_timing_chk (.clock_in, .rstn_in, .reg_wr_in, .reg_addr_in, .reg_be_in,
    .reg_wdata_in, .issue_valid_out, .issue_cmd_out, .write_data_start_out);

// *** dv/dcs_timing_top_bench.sv ***
`timescale 1ns/1ps
module dcs_timing_top_bench
    import dcs_pkg::*;
;
    logic clock_in = 0, rstn_in = 0, cmd_valid_in = 0, reg_wr_in = 0, reg_rd_in = 0;
    dcs_cmd_t    cmd_in = '0;
    logic [7:0]  reg_addr_in = 8'h00, viol;
    logic [3:0]  reg_be_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
    logic        cmd_accept_out, issue_valid_out, write_data_start_out;
    dcs_cmd_t    issue_cmd_out;
    int          failures = 0, checks = 0, cyc = 0, t0, t1;
    dcs_timing_top u_dcs_timing_top (.clock_in, .rstn_in, .cmd_valid_in, .cmd_in, .cmd_accept_out,
        .issue_valid_out, .issue_cmd_out, .write_data_start_out, .reg_wr_in, .reg_rd_in, .reg_addr_in,
        .reg_be_in, .reg_wdata_in, .reg_rdata_out);
    dcs_mem_model u_dcs_mem_model (.clock_in, .rstn_in, .issue_valid_out, .issue_cmd_out,
        .write_data_start_out, .viol_out(viol));
    initial begin
        forever #12.5 clock_in = ~clock_in;
    end
    // cycle count and hang guard
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk32
    task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        reg_wr_in <= wr;
        reg_rd_in <= !wr;
        reg_addr_in <= a;
        reg_be_in <= be;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        @(posedge clock_in);
    endtask : reg_acc
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
        reg_acc(1'b0, a, 4'h0, 32'h0);
        chk32(reg_rdata_out, e);
    endtask : reg_chk
    // request held until accepted, returns accept cycle
    task automatic cmd(input dcs_kind_t k, input logic [1:0] b, input logic [12:0] r, output int t);
        int n;
        n = 0;
        cmd_valid_in <= 1'b1;
        cmd_in <= '{kind: k, bank: b, row: r};
        do begin
            @(posedge clock_in);
            n++;
        end while (cmd_accept_out !== 1'b1 && n < 20);
        t = cyc;
        chk32(32'(issue_cmd_out), 32'({k, b, r}));
    endtask : cmd
    initial begin
        logic [7:0] v;
        repeat (2) @(posedge clock_in);
        rstn_in <= 1'b1;
        @(posedge clock_in);
        reg_chk(8'h60, 32'h18004425);
        reg_acc(1'b1, 8'h64, 4'hf, 32'hffffffff);
        reg_chk(8'h64, 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = {1'b0, i[0], i[1:0], 4'h8};
            reg_acc(1'b1, 8'h60, 4'h8, {v, 24'h0});
            reg_chk(8'h60, {v, 24'h004425});
            cmd(dcs_wr, 2'h0, 13'h1, t0);
            cmd(dcs_rd, 2'h1, 13'h2, t1);
            chk32(32'(t1 - t0), (i == 1) ? 32'h3 : (i == 2) ? 32'(1 + 4 / 2 + 1 - 2) : 32'h4);
            cmd(dcs_wr, 2'h0, 13'h1, t0);
            cmd(dcs_pre, 2'h0, 13'h0, t1);
            chk32(32'(t1 - t0), i[0] ? 32'h3 : 32'h2);
            cmd(dcs_wr, 2'h2, 13'h3, t0);
            cmd(dcs_rd, 2'h2, 13'h3, t1);
            chk32(32'(t1 - t0), 32'h2);
            cmd_valid_in <= 1'b0;
            repeat (2) @(posedge clock_in);
        end
        chk32({24'h0, viol}, 32'h0);
        wrap_up();
    end
endmodule : dcs_timing_top_bench
